// ---- quadrature_pulse_regenerator.v ----
// Feedback pulse regenerator with second in-position flag and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "qpr_defines.vh"
module quadrature_pulse_regenerator #(
	parameter DEV_W = 32
) (
	// APB
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Encoder feedback quadrature, asynchronous pins
	input wire enc_a,
	input wire enc_b,
	// External scale quadrature and index, asynchronous pins
	input wire scale_a,
	input wire scale_b,
	input wire scale_z,
	// Positional deviation, same clock domain
	input wire signed [DEV_W-1:0] deviation_cmd_unit,
	input wire signed [DEV_W-1:0] deviation_enc_unit,
	// Regenerated outputs
	output reg regen_phase_a_out,
	output reg regen_phase_b_out,
	output reg regen_phase_z_out,
	output reg in_position_flag_second,
	output reg regen_limit_error
);
	// Registers
	reg [18:0] output_pulses_per_rev;
	reg [18:0] output_divider_denominator;
	reg [1:0] b_logic_and_source_select;
	reg scale_output_method;
	reg regen_limit_detect_enable;
	reg position_unit_select;
	reg [18:0] second_in_position_threshold;
	reg [18:0] source_pulses_per_rev;
	reg [DEV_W-1:0] abs_dev;

	// Input synchronisers
	// Pins are unrelated to pclk, so each passes two stages first
	reg [4:0] sync1;
	reg [4:0] sync2;
	reg [1:0] prev_q;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1 <= 5'h00;
			sync2 <= 5'h00;
		end else begin
			sync1 <= {scale_z, scale_b, scale_a, enc_b, enc_a};
			sync2 <= sync1;
		end
	end

	wire use_scale = b_logic_and_source_select[1];
	wire src_a = use_scale ? sync2[2] : sync2[0];
	wire src_b = use_scale ? sync2[3] : sync2[1];

	// Quadrature decode of the selected source
	function [1:0] qdec;
		input [1:0] prev;
		input [1:0] cur;
		begin
			case ({prev, cur})
				// A moving ahead of B counts up, as the host counter does
				4'b0010, 4'b1011, 4'b1101, 4'b0100: qdec = 2'b01;
				4'b0001, 4'b0111, 4'b1110, 4'b1000: qdec = 2'b10;
				default: qdec = 2'b00;
			endcase
		end
	endfunction
	wire [1:0] src_step = qdec(prev_q[1:0], {src_a, src_b});

	// Effective ratio: numerator and denominator of the divider
	// denominator zero
	wire [18:0] div_num = output_pulses_per_rev;
	wire [18:0] div_den = (output_divider_denominator == 19'h00000) ?
		source_pulses_per_rev : output_divider_denominator;
	wire [18:0] eff_num = (div_num > div_den) ? div_den : div_num;

	// Rate accumulator: each up source edge adds num, each down edge takes it off, output edge per den
	// The remainder carries over, so fractional ratios hold over many turns
	reg [19:0] acc;
	reg [19:0] next_acc;
	reg next_up;
	reg next_dn;
	always @* begin
		next_acc = acc;
		next_up = 1'b0;
		next_dn = 1'b0;
		if (src_step == 2'b01) begin
			next_acc = acc + {1'b0, eff_num};
			if (next_acc >= {1'b0, div_den}) begin
				next_acc = next_acc - {1'b0, div_den};
				next_up = 1'b1;
			end
		end else if (src_step == 2'b10) begin
			if (acc < {1'b0, eff_num}) begin
				next_acc = acc + {1'b0, div_den} - {1'b0, eff_num};
				next_dn = 1'b1;
			end else begin
				next_acc = acc - {1'b0, eff_num};
			end
		end
	end
	reg step_up;
	reg step_dn;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_q <= 2'h0;
			acc <= 20'h00000;
			step_up <= 1'b0;
			step_dn <= 1'b0;
		end else begin
			prev_q <= {src_a, src_b};
			acc <= next_acc;
			step_up <= next_up;
			step_dn <= next_dn;
		end
	end

	wire gen_a;
	wire gen_b;
	wire gen_ovf;
	edge_pacer #(
		.GAP(`EDGE_GAP_CYC),
		.PEND_W(16)
	) u_pacer (
		.pclk(pclk),
		.presetn(presetn),
		.step_up(step_up),
		.step_dn(step_dn),
		.qa(gen_a),
		.qb(gen_b),
		.overflow(gen_ovf)
	);

	// Output stage
	// Pass-through skips the pacer, so the rate ceiling does not apply there
	wire pass_through = use_scale && !scale_output_method;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			regen_phase_a_out <= 1'b0;
			regen_phase_b_out <= 1'b0;
			regen_phase_z_out <= 1'b0;
			regen_limit_error <= 1'b0;
		end else begin
			regen_phase_a_out <= pass_through ? sync2[2] : gen_a;
			regen_phase_b_out <= (pass_through ? sync2[3] : gen_b) ^
				b_logic_and_source_select[0];
			regen_phase_z_out <= use_scale ? sync2[4] : 1'b0;
			// Sticky until software drops the enable bit
			// gated detect
			if (regen_limit_detect_enable && !pass_through && gen_ovf)
				regen_limit_error <= 1'b1;
			else if (!regen_limit_detect_enable)
				regen_limit_error <= 1'b0;
		end
	end

	// unit choice, residual deviation is honoured not masked
	wire signed [DEV_W-1:0] dev_sel = position_unit_select ?
		deviation_enc_unit : deviation_cmd_unit;
	// Two's complement magnitude; the most negative value maps to itself
	function [DEV_W-1:0] magnitude;
		input [DEV_W-1:0] v;
		begin
			if (v[DEV_W-1])
				magnitude = ~v + 1'b1;
			else
				magnitude = v;
		end
	endfunction
	always @* begin
		abs_dev = magnitude(dev_sel);
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			in_position_flag_second <= 1'b0;
		else
			in_position_flag_second <= (abs_dev < {{(DEV_W-19){1'b0}},
				second_in_position_threshold});
	end
	// is met by the caller supplying filtered-command deviation

	// APB slave: one access cycle, no extra wait states
	// Settings above the top of their range are held at the top
	function [18:0] clamp19;
		input [31:0] v;
		begin
			clamp19 = (v > `MAX_SETTING) ? `MAX_SETTING : v[18:0];
		end
	endfunction
	// A resolution of zero would stall the ratio, so it reads as one
	function [18:0] clamp_nonzero;
		input [31:0] v;
		begin
			if (v == 32'h00000000)
				clamp_nonzero = 19'h00001;
			else
				clamp_nonzero = clamp19(v);
		end
	endfunction
	// Settings read back zero-extended to the bus width
	function [31:0] widen19;
		input [18:0] v;
		begin
			widen19 = {13'h0000, v};
		end
	endfunction
	function reg_mapped;
		input [7:0] a;
		begin
			case (a)
				`APB_OFF_PULSES, `APB_OFF_DENOM, `APB_OFF_CTRL, `APB_OFF_SETTLE_THR,
				`APB_OFF_STATUS, `APB_OFF_DEVIATION, `APB_OFF_SRC_RES: reg_mapped = 1'b1;
				default: reg_mapped = 1'b0;
			endcase
		end
	endfunction
	wire wr = psel && penable && pwrite;
	wire known = reg_mapped(paddr);
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			output_pulses_per_rev <= `RST_PULSES;
			output_divider_denominator <= `RST_DENOM;
			b_logic_and_source_select <= 2'b00;
			scale_output_method <= 1'b0;
			regen_limit_detect_enable <= 1'b0;
			position_unit_select <= 1'b0;
			second_in_position_threshold <= `RST_SETTLE_THR;
			source_pulses_per_rev <= `RST_SRC_RES;
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable && !known;
			if (wr && pready) begin
				case (paddr)
					`APB_OFF_PULSES: output_pulses_per_rev <= clamp_nonzero(pwdata);
					`APB_OFF_DENOM: output_divider_denominator <= clamp19(pwdata);
					`APB_OFF_CTRL: begin
						b_logic_and_source_select <= pwdata[`CTRL_SRCSEL_LSB+1:`CTRL_SRCSEL_LSB];
						scale_output_method <= pwdata[`CTRL_METHOD_BIT];
						regen_limit_detect_enable <= pwdata[`CTRL_LIMEN_BIT];
						position_unit_select <= pwdata[`CTRL_UNIT_BIT];
					end
					`APB_OFF_SETTLE_THR: second_in_position_threshold <= clamp19(pwdata);
					`APB_OFF_SRC_RES: source_pulses_per_rev <= clamp_nonzero(pwdata);
					default: begin
					end
				endcase
			end
			if (psel && !penable && !pwrite) begin
				case (paddr)
					`APB_OFF_PULSES: prdata <= widen19(output_pulses_per_rev);
					`APB_OFF_DENOM: prdata <= widen19(output_divider_denominator);
					`APB_OFF_CTRL: prdata <= {27'h0000000, position_unit_select,
						regen_limit_detect_enable, scale_output_method,
						b_logic_and_source_select};
					`APB_OFF_SETTLE_THR: prdata <= widen19(second_in_position_threshold);
					`APB_OFF_STATUS: prdata <= {28'h0000000, regen_phase_b_out,
						regen_phase_a_out, regen_limit_error, in_position_flag_second};
					`APB_OFF_DEVIATION: prdata <= abs_dev;
					`APB_OFF_SRC_RES: prdata <= widen19(source_pulses_per_rev);
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // quadrature_pulse_regenerator
`default_nettype wire

// ---- qpr_defines.vh ----
// Constants for the quadrature pulse regenerator
`ifndef QPR_DEFINES_VH
`define QPR_DEFINES_VH
`define APB_OFF_PULSES 8'h00
`define APB_OFF_DENOM 8'h04
`define APB_OFF_CTRL 8'h08
`define APB_OFF_SETTLE_THR 8'h0C
`define APB_OFF_STATUS 8'h10
`define APB_OFF_DEVIATION 8'h14
`define APB_OFF_SRC_RES 8'h18
`define RST_PULSES 19'h00001
`define RST_DENOM 19'h00000
`define RST_SETTLE_THR 19'h00000
`define RST_SRC_RES 19'h20000
`define CTRL_SRCSEL_LSB 0
`define CTRL_METHOD_BIT 2
`define CTRL_LIMEN_BIT 3
`define CTRL_UNIT_BIT 4
`define MAX_SETTING 19'h40000
`define CLK_HZ 125000000
`define MAX_RATE_PPS 4000000
// Least spacing between output edges: ceil(clk / max edge rate)
`define EDGE_GAP_CYC ((`CLK_HZ + `MAX_RATE_PPS - 1) / `MAX_RATE_PPS)
`endif

// ---- edge_pacer.v ----
// Quadrature output stepper paced to the output rate ceiling
`timescale 1ns/1ps
`default_nettype none
`include "qpr_defines.vh"
module edge_pacer #(
	parameter GAP = `EDGE_GAP_CYC,
	parameter PEND_W = 16
) (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Step requests
	input wire step_up,
	input wire step_dn,
	// Quadrature state and overflow
	output reg qa,
	output reg qb,
	output reg overflow
);
	reg signed [PEND_W-1:0] pend;
	reg [7:0] gap_cnt;
	reg signed [PEND_W-1:0] next_pend;
	wire go_up = (pend > 0) && (gap_cnt == 8'h00);
	wire go_dn = (pend < 0) && (gap_cnt == 8'h00);
	localparam signed [PEND_W-1:0] PEND_MAX = {1'b0, {(PEND_W-1){1'b1}}};
	localparam signed [PEND_W-1:0] PEND_MIN = {1'b1, {(PEND_W-1){1'b0}}};
	always @* begin
		next_pend = pend;
		if (step_up && !step_dn && pend != PEND_MAX)
			next_pend = next_pend + 1'b1;
		if (step_dn && !step_up && pend != PEND_MIN)
			next_pend = next_pend - 1'b1;
		if (go_up)
			next_pend = next_pend - 1'b1;
		if (go_dn)
			next_pend = next_pend + 1'b1;
	end
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend <= {PEND_W{1'b0}};
			gap_cnt <= 8'h00;
			qa <= 1'b0;
			qb <= 1'b0;
			overflow <= 1'b0;
		end else begin
			pend <= next_pend;
			if (go_up || go_dn) begin
				gap_cnt <= GAP[7:0] - 8'h01;
				if (go_up ^ (qa ^ qb))
					qa <= ~qa;
				else
					qb <= ~qb;
			end else if (gap_cnt != 8'h00) begin
				gap_cnt <= gap_cnt - 8'h01;
			end
			overflow <= (pend == PEND_MAX) || (pend == PEND_MIN);
		end
	end
endmodule // edge_pacer
`default_nettype wire

// ---- qpr_chk.sv ----
// Port checks for the pulse regenerator
`timescale 1ns/1ps
`default_nettype none
`include "qpr_defines.vh"
module qpr_chk #(parameter DEV_W = 32) (
	// Bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	// Feedback side
	input wire logic signed [DEV_W-1:0] deviation_cmd_unit,
	input wire logic signed [DEV_W-1:0] deviation_enc_unit,
	input wire logic regen_phase_a_out,
	input wire logic regen_phase_b_out,
	input wire logic regen_phase_z_out,
	input wire logic in_position_flag_second,
	input wire logic regen_limit_error
);
	logic [31:0] thr;
	logic [4:0] ctrl;
	logic pa, pb;
	logic [5:0] gap;
	wire wr = psel && penable && pready && pwrite;
	wire signed [DEV_W-1:0] dv = ctrl[4] ? deviation_enc_unit : deviation_cmd_unit;
	wire [DEV_W-1:0] mag = dv[DEV_W-1] ? -dv : dv;
	wire below = mag < thr;
	wire flip = (regen_phase_a_out != pa) || (regen_phase_b_out != pb);
	// Shadow of the settings, so the checks track what software wrote
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			thr <= 32'h0;
			ctrl <= 5'h0;
			pa <= 1'b0;
			pb <= 1'b0;
			gap <= 6'h3F;
		end else begin
			if (wr && paddr == `APB_OFF_SETTLE_THR) thr <= pwdata;
			if (wr && paddr == `APB_OFF_CTRL) ctrl <= pwdata[4:0];
			pa <= regen_phase_a_out;
			pb <= regen_phase_b_out;
			gap <= flip ? 6'h0 : (gap == 6'h3F ? gap : gap + 6'h1);
		end
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_FLAG2: assert property (in_position_flag_second == $past(below))
		else $error("second in-position flag wrong");
	AST_ONE_PHASE: assert property (!(regen_phase_a_out != pa && regen_phase_b_out != pb))
		else $error("both phases changed together");
	AST_EDGE_GAP: assert property (flip |-> gap >= 6'd31)
		else $error("output edges too close");
	AST_NO_Z: assert property (!ctrl[1] && !$past(ctrl[1]) |-> !regen_phase_z_out)
		else $error("index pulse from encoder path");
	AST_LIM_OFF: assert property (!ctrl[3] && !$past(ctrl[3]) |-> !regen_limit_error)
		else $error("limit error while disabled");
	AST_READY: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("ready timing wrong");
	AST_UNMAPPED: assert property (psel && penable && pready && paddr > 8'h18 |-> pslverr)
		else $error("unmapped access not refused");
	AST_ERR_READY: assert property (pslverr |-> pready && psel && penable)
		else $error("error outside access");
	C_FLAG: cover property (in_position_flag_second);
	C_Z: cover property (regen_phase_z_out);
	C_STEP: cover property (flip);
endmodule // qpr_chk
`default_nettype wire

// ---- quad_host.sv ----
// Host counter model that counts quadrature edges four times per pulse
`timescale 1ns/1ps
`default_nettype none
module quad_host (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Quadrature from the block
	input wire logic a,
	input wire logic b,
	// Four-times count
	output var int count
);
	logic [1:0] prev;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev <= 2'b00;
			count <= 0;
		end else begin
			prev <= {a, b};
			case ({prev, a, b})
				4'b0010, 4'b1011, 4'b1101, 4'b0100: count <= count + 1;
				4'b0001, 4'b0111, 4'b1110, 4'b1000: count <= count - 1;
				default: ;
			endcase
		end
	end
endmodule // quad_host
`default_nettype wire

// ---- quadrature_pulse_regenerator_bench.sv ----
// Self-checking bench for the pulse regenerator
`timescale 1ns/1ps
`default_nettype none
`include "qpr_defines.vh"
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin n_fail++; \
	$display("MISMATCH %s exp %0h got %0h", n, e, s); end end
module quadrature_pulse_regenerator_bench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'hA8DF;
	logic pready, pslverr, out_a, out_b, out_z, enc_a = 0, enc_b = 0, sa = 0, sb = 0, sz = 0;
	logic signed [31:0] dc = 0, de = 0;
	logic [64:0] q[$];
	logic [64:0] e;
	logic [1:0] p = 2'b00;
	int n_fail = 0, n_checks = 0, cnt, base, i, s;
	logic [31:0] rv[6] = '{32'h1, 32'h0, 32'h0, 32'h0, 32'h20000, 32'h0};
	logic [7:0] ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h18, 8'h1C};
	quadrature_pulse_regenerator dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .enc_a(enc_a), .enc_b(enc_b),
		.scale_a(sa), .scale_b(sb), .scale_z(sz), .deviation_cmd_unit(dc),
		.deviation_enc_unit(de), .regen_phase_a_out(out_a), .regen_phase_b_out(out_b),
		.regen_phase_z_out(out_z), .in_position_flag_second(), .regen_limit_error());
	quad_host host (.pclk(pclk), .presetn(presetn), .a(out_a), .b(out_b), .count(cnt));
	initial begin
		forever #4 pclk = ~pclk;
	end
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task close_out;
		if (n_fail == 0 && n_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Reads note mask, refusal and data; the monitor compares them
	task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
		int k;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		if (!w) q.push_back({m, a > 8'h18, d & m});
		@(posedge pclk);
		penable <= 1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) begin
			n_fail++;
			close_out();
		end
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	// Step both pin sets together so a source change never jumps
	task steps(input int n, input bit up, input int exp);
		int k;
		repeat (40) @(posedge pclk);
		base = cnt;
		for (k = 0; k < n; k++) begin
			p = up ? p + 2'd1 : p - 2'd1;
			{enc_a, enc_b, sa, sb, sz} <= {p[1] ^ p[0], p[1], p[1] ^ p[0], p[1], p == 2'd0};
			repeat (40) @(posedge pclk);
		end
		`CHK("host count", exp, cnt - base)
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			if (q.size() == 0) e = 65'h0;
			else e = q.pop_front();
			`CHK("apb read", e[32:0], {pslverr, prdata & e[64:33]})
		end
	end
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		for (i = 0; i < 6; i++) xfer(0, ra[i], rv[i], 32'hFFFFFFFF);
		xfer(1, 8'h1C, 32'h5, 0);
		xfer(1, `APB_OFF_SETTLE_THR, 32'h64, 0);
		for (i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			xfer(1, `APB_OFF_CTRL, {27'h0, i[0], 4'h0}, 0);
			if (i > 5) begin
				dc <= (i == 6) ? 32'sd99 : -32'sd100;
				de <= (i == 6) ? 32'sd99 : -32'sd100;
			end else begin
				dc <= $signed({24'h0, seed[7:0]}) - 128;
				de <= $signed({24'h0, seed[15:8]}) - 128;
			end
			@(posedge pclk);
			@(posedge pclk);
			xfer(0, `APB_OFF_STATUS, {31'h0, (i[0] ? (de < 0 ? -de : de) : (dc < 0 ? -dc : dc)) < 100}, 1);
		end
		xfer(1, `APB_OFF_PULSES, 32'h20000, 0);
		// encoder and scale sources, each with B logic plain and inverted
		for (s = 0; s < 4; s++) begin
			xfer(1, `APB_OFF_CTRL, s, 0);
			steps(8, 1, s[0] ? -8 : 8);
			`CHK("index out", s[1], out_z)
		end
		xfer(1, `APB_OFF_CTRL, 32'hE, 0);
		steps(8, 0, -8);
		`CHK("index out", 1'b1, out_z)
		xfer(1, `APB_OFF_CTRL, 32'h8, 0);
		xfer(1, `APB_OFF_PULSES, 32'h40000, 0);
		steps(8, 1, 8);
		`CHK("index out", 1'b0, out_z)
		xfer(1, `APB_OFF_PULSES, 32'h10000, 0);
		steps(8, 1, 4);
		xfer(1, `APB_OFF_PULSES, 32'h1, 0);
		xfer(1, `APB_OFF_DENOM, 32'h4, 0);
		steps(8, 1, 2);
		xfer(0, `APB_OFF_STATUS, 32'h0, 32'h2);
		close_out();
	end
endmodule // quadrature_pulse_regenerator_bench
bind quadrature_pulse_regenerator qpr_chk #(.DEV_W(DEV_W)) u_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.pready(pready), .pslverr(pslverr), .deviation_cmd_unit(deviation_cmd_unit),
	.deviation_enc_unit(deviation_enc_unit), .regen_phase_a_out(regen_phase_a_out),
	.regen_phase_b_out(regen_phase_b_out), .regen_phase_z_out(regen_phase_z_out),
	.in_position_flag_second(in_position_flag_second), .regen_limit_error(regen_limit_error));
`default_nettype wire
